// [sps_ms_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module sps_ms_timer #(
	parameter int unsigned CYCLES_PER_MS = sps_pkg::CYCLES_PER_MS
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic [15:0] ms_in,
	output logic tick_out,
	output logic expire_out
);
	localparam logic [15:0] PRE_LAST = 16'(CYCLES_PER_MS - 1);
	localparam logic [15:0] ONE = 16'h0001;
	logic [15:0] pre_reg;
	logic [15:0] rem_reg;
	logic busy_reg;

	// ----------------------------------------------------------------
	// millisecond prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_reg <= '0;
			tick_out <= 1'b0;
		end else if (ce_in && start_in) begin
			// restart so a countdown lasts whole milliseconds
			pre_reg <= '0;
			tick_out <= 1'b0;
		end else if (ce_in) begin
			tick_out <= (pre_reg == PRE_LAST);
			pre_reg <= (pre_reg == PRE_LAST) ? '0 : pre_reg + ONE;
		end
	end

	// ----------------------------------------------------------------
	// countdown in whole ms, one-cycle expire pulse
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rem_reg <= '0;
			busy_reg <= 1'b0;
			expire_out <= 1'b0;
		end else if (ce_in) begin
			expire_out <= 1'b0;
			if (start_in) begin
				rem_reg <= ms_in;
				busy_reg <= 1'b1;
			end else if (busy_reg && rem_reg == '0) begin
				busy_reg <= 1'b0;
				expire_out <= 1'b1;
			end else if (busy_reg && tick_out) begin
				rem_reg <= rem_reg - ONE;
			end
		end
	end
endmodule : sps_ms_timer
`default_nettype wire

// [sps_pkg.sv]
`default_nettype none
package sps_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TICK_MS = 1; // base time unit in ms
	localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S * TICK_MS;

	// ----------------------------------------------------------------
	// sizes and codes
	// ----------------------------------------------------------------
	localparam logic [3:0] NUM_PATHS = 4'h8;
	localparam logic [3:0] HOMING_PATH = 4'h0;
	localparam logic [3:0] FIRST_PATH = 4'h1;
	localparam int SET_COUNT = 16;
	localparam logic [3:0] TYPE_SPEED = 4'h1;
	localparam logic [3:0] BOOT_ON = 4'h1;
	localparam logic [15:0] DWELL_MASK = 16'h7fff;
	localparam logic [31:0] POS_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// path control word fields
	// ----------------------------------------------------------------
	localparam int TYPE_LSB = 0;
	localparam int INS_BIT = 4;
	localparam int OVERLAP_NEXT_BIT_BIT = 5;
	localparam int INC_BIT = 7;
	localparam int RAMP_LSB = 8;
	localparam int SLOW_LSB = 12;
	localparam int VEL_LSB = 16;
	localparam int DWELL_LSB = 20;
	// homing definition word fields
	localparam int BOOT_LSB = 0;
	localparam int FOLLOW_LSB = 4;
	localparam int SLOW2_LSB = 16;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SPS_K_VEL, SPS_K_RAMP, SPS_K_DWELL, SPS_K_CTRL,
		SPS_K_TARGET, SPS_K_HOMEDEF, SPS_K_HOMECOORD, SPS_K_SWTRIG
	} sps_kind_t;

	typedef struct packed {
		logic wr;
		sps_kind_t kind;
		logic [3:0] idx;
		logic [31:0] data;
	} sps_param_req_t;

	typedef struct packed {
		logic interrupt_previous_bit;
		logic overlap_next_bit;
		logic inc;
		logic speed;
		logic [3:0] ramp;
		logic [3:0] slow;
		logic [3:0] vel;
		logic [3:0] dwell;
		logic signed [31:0] target;
	} sps_path_t;

	typedef enum logic [2:0] {
		SPS_ST_IDLE, SPS_ST_MOVE, SPS_ST_SPEED, SPS_ST_HOMING,
		SPS_ST_STOPPING, SPS_ST_DWELL
	} sps_state_t;

	// split a stored path into its fields
	function automatic sps_path_t sps_decode(input logic [31:0] w0,
		input logic [31:0] w1);
		sps_path_t p;
		p.interrupt_previous_bit = w0[INS_BIT];
		p.overlap_next_bit = w0[OVERLAP_NEXT_BIT_BIT];
		p.inc = w0[INC_BIT];
		p.speed = (w0[TYPE_LSB +: 4] == TYPE_SPEED);
		p.ramp = w0[RAMP_LSB +: 4];
		p.slow = w0[SLOW_LSB +: 4];
		p.vel = w0[VEL_LSB +: 4];
		p.dwell = w0[DWELL_LSB +: 4];
		p.target = w1;
		return p;
	endfunction : sps_decode
endpackage : sps_pkg
`default_nettype wire

// [sps_plc.sv]
`timescale 1ns/100ps
`default_nettype none
module sps_plc (
	input wire logic clk_in,
	output logic trig_out,
	output logic [2:0] sel_out,
	output logic halt_out,
	output logic home_out
);
	// all lines idle low at start
	initial begin
		trig_out = 1'b0;
		sel_out = 3'h0;
		halt_out = 1'b0;
		home_out = 1'b0;
	end
	// select settles a cycle before the trigger edge
	task automatic start_path(input logic [2:0] n);
		@(posedge clk_in) #1 sel_out = n;
		@(posedge clk_in) #1 trig_out = 1'b1;
		@(posedge clk_in) #1 trig_out = 1'b0;
	endtask : start_path
	// off to on edge of halt or homing start, held two cycles
	task automatic rise(input logic is_halt);
		@(posedge clk_in) #1;
		if (is_halt) halt_out = 1'b1;
		else home_out = 1'b1;
		@(posedge clk_in) #1;
		@(posedge clk_in) #1 halt_out = 1'b0;
		home_out = 1'b0;
	endtask : rise
endmodule : sps_plc
`default_nettype wire

// [sps_sequencer.sv]
// How it works
// - path zero homes, paths one to eight stored
// - trigger rising edge starts the selected path
// - halt rising edge stops the running path
// - homing start rising edge begins homing
// - software trigger write launches path immediately
// - sixteen 16-bit velocity settings kept
// - sixteen 16-bit ramp time settings kept
// - sixteen dwell settings, 0 to 32767 ms
// - path is control word plus signed target
// - absolute loads target, incremental adds it
// - interrupt-previous path aborts the running one
// - homing follow-on field picks next path
// - boot field homes at first servo enable
// - homing end sets home coordinate as command position
// - soft limit checks off during homing
// - interrupt outranks overlap of previous path
// - overlap ignored when next is speed command
// - stops keep stepping at path velocity for the ramp time the slowdown field selects
// - running path obeys halt, and soft limits except while homing
// - servo enable loads feedback into positions
// - done drops on accept, rises at end
`timescale 1ns/100ps
`default_nettype none
module sps_sequencer #(
	parameter int unsigned CYCLES_PER_MS = sps_pkg::CYCLES_PER_MS
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic servo_on_in,
	input wire logic path_trigger_input_in,
	input wire logic [2:0] path_select_in,
	input wire logic halt_input_in,
	input wire logic homing_start_input_in,
	input wire logic emergency_halt_input_in,
	input wire logic forward_soft_limit_in,
	input wire logic reverse_soft_limit_in,
	input wire logic index_pulse_in,
	input wire logic [31:0] feedback_pos_in,
	input wire sps_pkg::sps_param_req_t param_req_in,
	input wire sps_pkg::sps_kind_t param_rd_kind_in,
	input wire logic [3:0] param_rd_idx_in,
	output logic [31:0] param_rd_data_out,
	output logic [31:0] cmd_position_out,
	output logic [31:0] end_position_out,
	output logic cmd_done_out,
	output logic homed_out,
	output logic homing_active_out,
	output logic soft_limit_check_out,
	output logic [3:0] active_path_out,
	output logic [15:0] velocity_out,
	output logic [15:0] ramp_time_out
);
	logic rst_meta_reg, rst_n;
	logic trig_q, halt_q, home_q, servo_q;
	logic [15:0] vel_mem [sps_pkg::SET_COUNT];
	logic [15:0] ramp_mem [sps_pkg::SET_COUNT];
	logic [15:0] dwell_mem [sps_pkg::SET_COUNT];
	logic [31:0] ctrl_mem [sps_pkg::NUM_PATHS];
	logic [31:0] tgt_mem [sps_pkg::NUM_PATHS];
	logic [31:0] home_def_reg, home_coord_reg;
	sps_pkg::sps_state_t state;
	sps_pkg::sps_path_t cur_reg, go_path, pend_path, launch_path, home_path;
	logic signed [31:0] cmd_reg, end_reg, go_end, go_target;
	logic signed [31:0] diff, vel32, step_cmd, speed_cmd;
	logic [3:0] cur_num_reg, pend_num_reg, launch_num, go_num, follow;
	logic pend_valid_reg, done_reg, homed_reg, booted_reg;
	logic tmr_start_reg, tick, tmr_expire, near;
	logic [15:0] tmr_ms_reg, stop_ramp;
	logic trig_rise, halt_rise, home_rise, servo_rise;
	logic sw_wr, sw_go, sw_stop, launch_valid, home_launch;
	logic stop_req, moving, stop_hit, go_valid, limit_check;
	// signed zero keeps the direction compare signed
	localparam logic signed [31:0] POS_ZERO = sps_pkg::POS_RESET;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// reset release and input edges
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// previous input levels for edge detection
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			{trig_q, halt_q, home_q, servo_q} <= '0;
		end else if (ce_in) begin
			trig_q <= path_trigger_input_in;
			halt_q <= halt_input_in;
			home_q <= homing_start_input_in;
			servo_q <= servo_on_in;
		end
	end

	assign trig_rise = path_trigger_input_in && !trig_q;
	assign halt_rise = halt_input_in && !halt_q;
	assign home_rise = homing_start_input_in && !home_q;
	assign servo_rise = servo_on_in && !servo_q;

	// ----------------------------------------------------------------
	// parameter storage
	// ----------------------------------------------------------------
	for (genvar g = 0; g < sps_pkg::SET_COUNT; g++) begin : g_set
		// one selectable setting of each kind, plus a path slot for the first eight
		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				vel_mem[g] <= '0;
				ramp_mem[g] <= '0;
				dwell_mem[g] <= '0;
			end else if (ce_in && param_req_in.wr &&
				param_req_in.idx == 4'(g)) begin
				if (param_req_in.kind == sps_pkg::SPS_K_VEL)
					vel_mem[g] <= param_req_in.data[15:0];
				if (param_req_in.kind == sps_pkg::SPS_K_RAMP)
					ramp_mem[g] <= param_req_in.data[15:0];
				if (param_req_in.kind == sps_pkg::SPS_K_DWELL)
					dwell_mem[g] <= param_req_in.data[15:0] &
						sps_pkg::DWELL_MASK;
			end
		end
		if (g < sps_pkg::NUM_PATHS) begin : g_path
			// path g+1 lives in slot g
			always_ff @(posedge clk_in or negedge rst_n) begin
				if (!rst_n) begin
					ctrl_mem[g] <= '0;
					tgt_mem[g] <= '0;
				end else if (ce_in && param_req_in.wr &&
					param_req_in.idx == 4'(g + 1)) begin
					if (param_req_in.kind == sps_pkg::SPS_K_CTRL)
						ctrl_mem[g] <= param_req_in.data;
					if (param_req_in.kind == sps_pkg::SPS_K_TARGET)
						tgt_mem[g] <= param_req_in.data;
				end
			end
		end
	end

	// homing definition and home coordinate
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			home_def_reg <= '0;
			home_coord_reg <= '0;
		end else if (ce_in && param_req_in.wr) begin
			if (param_req_in.kind == sps_pkg::SPS_K_HOMEDEF)
				home_def_reg <= param_req_in.data;
			if (param_req_in.kind == sps_pkg::SPS_K_HOMECOORD)
				home_coord_reg <= param_req_in.data;
		end
	end

	// registered read of the readable parameters
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			param_rd_data_out <= '0;
		end else if (ce_in) begin
			param_rd_data_out <= '0;
			if (param_rd_kind_in == sps_pkg::SPS_K_HOMEDEF) begin
				param_rd_data_out <= home_def_reg;
			end else if (param_rd_kind_in == sps_pkg::SPS_K_HOMECOORD) begin
				param_rd_data_out <= home_coord_reg;
			end else if (param_rd_idx_in >= sps_pkg::FIRST_PATH &&
				param_rd_idx_in <= sps_pkg::NUM_PATHS) begin
				if (param_rd_kind_in == sps_pkg::SPS_K_CTRL)
					param_rd_data_out <= ctrl_mem[3'(param_rd_idx_in - 4'h1)];
				else if (param_rd_kind_in == sps_pkg::SPS_K_TARGET)
					param_rd_data_out <= tgt_mem[3'(param_rd_idx_in - 4'h1)];
			end
		end
	end

	// ----------------------------------------------------------------
	// launch and stop sources
	// ----------------------------------------------------------------
	assign sw_wr = param_req_in.wr &&
		param_req_in.kind == sps_pkg::SPS_K_SWTRIG;
	assign sw_go = sw_wr && param_req_in.data <= 32'(sps_pkg::NUM_PATHS);
	assign sw_stop = sw_wr && param_req_in.data > 32'(sps_pkg::NUM_PATHS);
	assign launch_valid = sw_go || home_rise || trig_rise;
	assign launch_num = sw_go ? param_req_in.data[3:0] :
		home_rise ? sps_pkg::HOMING_PATH : {1'b0, path_select_in};
	assign home_launch = launch_valid && launch_num == sps_pkg::HOMING_PATH;
	assign limit_check = (state != sps_pkg::SPS_ST_HOMING);
	assign stop_req = halt_rise || sw_stop || emergency_halt_input_in ||
		(limit_check && (forward_soft_limit_in || reverse_soft_limit_in));
	assign moving = state == sps_pkg::SPS_ST_MOVE ||
		state == sps_pkg::SPS_ST_SPEED || state == sps_pkg::SPS_ST_HOMING;
	assign stop_hit = stop_req && (moving || state == sps_pkg::SPS_ST_DWELL);

	// decoded paths of the launch, the pending slot and the homing word
	assign launch_path = sps_pkg::sps_decode(
		ctrl_mem[3'(launch_num - 4'h1)], tgt_mem[3'(launch_num - 4'h1)]);
	assign pend_path = sps_pkg::sps_decode(
		ctrl_mem[3'(pend_num_reg - 4'h1)], tgt_mem[3'(pend_num_reg - 4'h1)]);
	assign go_path = sps_pkg::sps_decode(
		ctrl_mem[3'(go_num - 4'h1)], tgt_mem[3'(go_num - 4'h1)]);
	// homing keeps velocity zero and stops over its first slowdown
	assign home_path = sps_pkg::sps_decode({8'h00,
		home_def_reg[sps_pkg::DWELL_LSB +: 4], 4'h0,
		home_def_reg[sps_pkg::RAMP_LSB +: 8], 8'h00}, POS_ZERO);
	assign follow = home_def_reg[sps_pkg::FOLLOW_LSB +: 4];
	assign go_target = go_path.target;

	// picks the path that starts this cycle, if any
	always_comb begin
		go_valid = 1'b0;
		go_num = pend_num_reg;
		case (state)
			sps_pkg::SPS_ST_IDLE: go_valid = pend_valid_reg;
			sps_pkg::SPS_ST_MOVE:
				go_valid = tick && near && pend_valid_reg && cur_reg.overlap_next_bit &&
					!pend_path.speed;
			sps_pkg::SPS_ST_DWELL: go_valid = tmr_expire && pend_valid_reg;
			sps_pkg::SPS_ST_HOMING: begin
				go_valid = index_pulse_in && follow != sps_pkg::HOMING_PATH &&
					follow <= sps_pkg::NUM_PATHS;
				go_num = follow;
			end
			default: go_valid = 1'b0;
		endcase
		if (launch_valid && !home_launch &&
			(state == sps_pkg::SPS_ST_IDLE || launch_path.interrupt_previous_bit)) begin
			go_valid = 1'b1;
			go_num = launch_num;
		end
		if (!servo_on_in || servo_rise || stop_hit || home_launch)
			go_valid = 1'b0;
	end

	// ----------------------------------------------------------------
	// position stepping
	// ----------------------------------------------------------------
	assign go_end = go_path.inc ? ((state == sps_pkg::SPS_ST_HOMING) ?
		home_coord_reg : end_reg) + go_path.target : go_path.target;
	assign vel32 = {16'h0000, vel_mem[cur_reg.vel]};
	assign diff = end_reg - cmd_reg;
	assign near = (diff <= vel32) && (diff >= -vel32);
	assign step_cmd = near ? end_reg :
		(diff > POS_ZERO) ? cmd_reg + vel32 : cmd_reg - vel32;
	assign speed_cmd = cur_reg.target[31] ? cmd_reg - vel32 : cmd_reg + vel32;
	assign stop_ramp = ramp_mem[cur_reg.slow];

	sps_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.ce_in(ce_in),
		.start_in(tmr_start_reg),
		.ms_in(tmr_ms_reg),
		.tick_out(tick),
		.expire_out(tmr_expire)
	);

	// ----------------------------------------------------------------
	// sequencer state, positions and done flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= sps_pkg::SPS_ST_IDLE;
			cmd_reg <= sps_pkg::POS_RESET;
			end_reg <= sps_pkg::POS_RESET;
			cur_reg <= '0;
			cur_num_reg <= sps_pkg::HOMING_PATH;
			pend_valid_reg <= 1'b0;
			pend_num_reg <= sps_pkg::FIRST_PATH;
			done_reg <= 1'b1;
			homed_reg <= 1'b0;
			booted_reg <= 1'b0;
			tmr_start_reg <= 1'b0;
			tmr_ms_reg <= '0;
		end else if (ce_in) begin
			tmr_start_reg <= 1'b0;
			if (!servo_on_in) begin
				state <= sps_pkg::SPS_ST_IDLE;
				pend_valid_reg <= 1'b0;
			end else if (servo_rise) begin
				cmd_reg <= feedback_pos_in;
				end_reg <= feedback_pos_in;
				booted_reg <= 1'b1;
				pend_valid_reg <= 1'b0;
				state <= sps_pkg::SPS_ST_IDLE;
				if (!booted_reg && home_def_reg[sps_pkg::BOOT_LSB +: 4] ==
					sps_pkg::BOOT_ON) begin
					state <= sps_pkg::SPS_ST_HOMING;
					done_reg <= 1'b0;
					homed_reg <= 1'b0;
					cur_reg <= home_path;
					cur_num_reg <= sps_pkg::HOMING_PATH;
				end
			end else if (stop_hit) begin
				pend_valid_reg <= 1'b0;
				if (moving) begin
					state <= sps_pkg::SPS_ST_STOPPING;
					tmr_start_reg <= 1'b1;
					tmr_ms_reg <= stop_ramp;
				end else begin
					state <= sps_pkg::SPS_ST_IDLE;
				end
			end else if (home_launch) begin
				state <= sps_pkg::SPS_ST_HOMING;
				done_reg <= 1'b0;
				homed_reg <= 1'b0;
				cur_reg <= home_path;
				cur_num_reg <= sps_pkg::HOMING_PATH;
				pend_valid_reg <= 1'b0;
			end else if (go_valid) begin
				if (state == sps_pkg::SPS_ST_HOMING) begin
					cmd_reg <= home_coord_reg;
					homed_reg <= 1'b1;
				end
				cur_reg <= go_path;
				cur_num_reg <= go_num;
				pend_valid_reg <= 1'b0;
				done_reg <= 1'b0;
				if (go_path.speed) begin
					state <= sps_pkg::SPS_ST_SPEED;
				end else begin
					state <= sps_pkg::SPS_ST_MOVE;
					end_reg <= go_end;
				end
			end else begin
				if (launch_valid) begin
					pend_valid_reg <= 1'b1;
					pend_num_reg <= launch_num;
				end
				case (state)
					sps_pkg::SPS_ST_MOVE: begin
						if (tick) begin
							cmd_reg <= step_cmd;
							if (near) begin
								done_reg <= 1'b1;
								state <= sps_pkg::SPS_ST_IDLE;
								if (pend_valid_reg) begin
									state <= sps_pkg::SPS_ST_DWELL;
									tmr_start_reg <= 1'b1;
									tmr_ms_reg <= dwell_mem[cur_reg.dwell];
								end
							end
						end
					end
					sps_pkg::SPS_ST_SPEED: begin
						if (tick) begin
							cmd_reg <= speed_cmd;
							end_reg <= speed_cmd;
						end
						if (pend_valid_reg) begin
							state <= sps_pkg::SPS_ST_DWELL;
							tmr_start_reg <= 1'b1;
							tmr_ms_reg <= dwell_mem[cur_reg.dwell];
						end
					end
					sps_pkg::SPS_ST_HOMING: begin
						if (index_pulse_in) begin
							cmd_reg <= home_coord_reg;
							end_reg <= home_coord_reg;
							done_reg <= 1'b1;
							homed_reg <= 1'b1;
							state <= sps_pkg::SPS_ST_IDLE;
						end
					end
					sps_pkg::SPS_ST_STOPPING: begin
						if (tmr_expire) begin
							end_reg <= cmd_reg;
							done_reg <= 1'b1;
							state <= sps_pkg::SPS_ST_IDLE;
						end else if (tick) begin
							cmd_reg <= cur_reg.speed ? speed_cmd : step_cmd;
						end
					end
					sps_pkg::SPS_ST_DWELL: begin
						if (tmr_expire)
							state <= sps_pkg::SPS_ST_IDLE;
					end
					default: state <= sps_pkg::SPS_ST_IDLE;
				endcase
			end
		end
	end

	// outputs
	assign cmd_position_out = cmd_reg;
	assign end_position_out = end_reg;
	assign cmd_done_out = done_reg;
	assign homed_out = homed_reg;
	assign homing_active_out = (state == sps_pkg::SPS_ST_HOMING);
	assign soft_limit_check_out = limit_check;
	assign active_path_out = cur_num_reg;
	assign velocity_out = vel_mem[cur_reg.vel];
	assign ramp_time_out = ramp_mem[cur_reg.ramp];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_halt_hit;
		ce_in && halt_rise && servo_on_in && !servo_rise && moving;
	endsequence
	sequence s_stop_entry;
		ce_in && stop_hit && moving && servo_on_in && !servo_rise;
	endsequence

	halt_stop_a: assert property (s_halt_hit |=>
		state == sps_pkg::SPS_ST_STOPPING) else $error("halt did not stop");
	stop_ramp_a: assert property (s_stop_entry |=>
		tmr_start_reg && tmr_ms_reg == $past(stop_ramp))
		else $error("stop ramp not loaded");
	done_clear_a: assert property (ce_in && go_valid |=>
		!cmd_done_out) else $error("done not cleared on accept");
	home_start_a: assert property (ce_in && home_rise && servo_on_in &&
		!servo_rise && !stop_hit |=> homing_active_out && !cmd_done_out)
		else $error("homing did not start");
	abs_end_a: assert property (ce_in && go_valid && !go_path.inc &&
		!go_path.speed |=> end_reg == $past(go_target))
		else $error("absolute end wrong");
	inc_end_a: assert property (ce_in && go_valid && go_path.inc &&
		!go_path.speed && state != sps_pkg::SPS_ST_HOMING |=>
		end_reg == $past(end_reg) + $past(go_target))
		else $error("incremental end wrong");
	home_coord_a: assert property (ce_in && homing_active_out &&
		index_pulse_in && servo_on_in && !servo_rise && !stop_hit &&
		!home_launch |=> cmd_reg == $past(home_coord_reg) && homed_out)
		else $error("home coordinate not applied");
	limit_off_a: assert property (homing_active_out |->
		!soft_limit_check_out) else $error("limits active in homing");
	servo_init_a: assert property (ce_in && servo_rise |=>
		cmd_reg == $past(feedback_pos_in) && end_reg == cmd_reg)
		else $error("servo on did not load feedback");
	ins_abort_a: assert property (ce_in && go_valid && launch_valid &&
		launch_path.interrupt_previous_bit && state == sps_pkg::SPS_ST_MOVE |=>
		active_path_out == $past(launch_num)) else $error("no abort");
endmodule : sps_sequencer
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int unsigned CPM = 20;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic servo_on = 1'b0;
	logic index_pulse = 1'b0;
	logic [31:0] fb_pos = 32'h0000_0000;
	logic ce = 1'b1;
	logic estop = 1'b0;
	logic lim_f = 1'b0;
	logic lim_r = 1'b0;
	sps_pkg::sps_param_req_t req = '0;
	sps_pkg::sps_kind_t rd_kind = sps_pkg::SPS_K_VEL;
	logic [3:0] rd_idx = 4'h0;
	logic trig, halt, home;
	logic [2:0] sel;
	logic [31:0] rd_data, cmd_pos, end_pos, inc;
	logic done, homed, hom_act, lim_chk;
	logic [3:0] act_path;
	logic [15:0] vel, ramp;
	int n_mismatch = 0;
	int tests_run = 0;
	int n;
	logic [34:0] exp_q[$];
	event probe;
	sps_plc sps_plc_inst (.clk_in(clk_in), .trig_out(trig), .sel_out(sel),
		.halt_out(halt), .home_out(home));
	sps_sequencer #(.CYCLES_PER_MS(CPM)) sps_sequencer_inst (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
		.servo_on_in(servo_on), .path_trigger_input_in(trig),
		.path_select_in(sel), .halt_input_in(halt),
		.homing_start_input_in(home), .emergency_halt_input_in(estop),
		.forward_soft_limit_in(lim_f), .reverse_soft_limit_in(lim_r),
		.index_pulse_in(index_pulse), .feedback_pos_in(fb_pos),
		.param_req_in(req), .param_rd_kind_in(rd_kind),
		.param_rd_idx_in(rd_idx), .param_rd_data_out(rd_data),
		.cmd_position_out(cmd_pos), .end_position_out(end_pos),
		.cmd_done_out(done), .homed_out(homed),
		.homing_active_out(hom_act), .soft_limit_check_out(lim_chk),
		.active_path_out(act_path), .velocity_out(vel),
		.ramp_time_out(ramp));
	// 40 MHz clock
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// note an expectation: 0 end,1 cmd,2 done,3 homed,4 homing,5 limits,6 read
	task automatic note(input logic [2:0] s, input logic [31:0] v);
		exp_q.push_back({s, v});
		->probe;
		#0.1;
	endtask : note
	// watcher takes the oldest note and compares the selected output
	always @(probe) begin : watch
		logic [34:0] e;
		logic [31:0] got;
		e = exp_q.pop_front();
		case (e[34:32])
			3'd0: got = end_pos;
			3'd1: got = cmd_pos;
			3'd2: got = {31'h0, done};
			3'd3: got = {31'h0, homed};
			3'd4: got = {31'h0, hom_act};
			3'd5: got = {31'h0, lim_chk};
			default: got = rd_data;
		endcase
		check(got, e[31:0]);
	end
	task automatic wr(input sps_pkg::sps_kind_t k, input logic [3:0] i,
		input logic [31:0] d);
		@(posedge clk_in) #1 req = '{1'b1, k, i, d};
		@(posedge clk_in) #1 req.wr = 1'b0;
	endtask : wr
	task automatic wait_done();
		n = 0;
		while (n < 3000 && done !== 1'b1) begin
			@(posedge clk_in) #1;
			n++;
		end
		if (done !== 1'b1) n_mismatch++;
	endtask : wait_done
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// watchdog for a hung run
	initial begin
		#2_000_000;
		n_mismatch++;
		print_verdict();
	end
	// main sequence
	initial begin : main
		void'($urandom(29));
		inc = $urandom_range(60, 40);
		fb_pos = $urandom_range(90, 1);
		repeat (20) @(posedge clk_in);
		#1 reset_n_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#1 note(3'd2, 32'h1);
		wr(sps_pkg::SPS_K_VEL, 4'h2, 32'h0000_0005);
		wr(sps_pkg::SPS_K_RAMP, 4'h3, 32'h0000_0002);
		wr(sps_pkg::SPS_K_CTRL, 4'h1, 32'h0002_3300);
		wr(sps_pkg::SPS_K_TARGET, 4'h1, 32'h0000_0064);
		wr(sps_pkg::SPS_K_CTRL, 4'h2, 32'h0002_3380);
		wr(sps_pkg::SPS_K_TARGET, 4'h2, inc);
		wr(sps_pkg::SPS_K_HOMEDEF, 4'h0, 32'h0000_0010);
		wr(sps_pkg::SPS_K_HOMECOORD, 4'h0, 32'h0000_0064);
		rd_kind = sps_pkg::SPS_K_CTRL;
		rd_idx = 4'h1;
		servo_on = 1'b1;
		repeat (2) @(posedge clk_in) #1;
		note(3'd6, 32'h0002_3300);
		note(3'd0, fb_pos);
		note(3'd1, fb_pos);
		$display("test setup done");
		sps_plc_inst.start_path(3'h1);
		note(3'd2, 32'h0);
		note(3'd0, 32'h0000_0064);
		wait_done();
		note(3'd1, 32'h0000_0064);
		sps_plc_inst.start_path(3'h2);
		note(3'd0, 32'h0000_0064 + inc);
		wait_done();
		note(3'd1, 32'h0000_0064 + inc);
		$display("test paths done");
		wr(sps_pkg::SPS_K_SWTRIG, 4'h0, 32'h0000_0001);
		note(3'd0, 32'h0000_0064);
		sps_plc_inst.rise(1'b1);
		wait_done();
		check({31'h0, n >= 2 * CPM - 4 && n <= 2 * CPM + 4}, 32'h1);
		$display("test halt done");
		sps_plc_inst.rise(1'b0);
		note(3'd4, 32'h1);
		note(3'd5, 32'h0);
		// soft limits while homing must not stop it
		@(posedge clk_in) #1 lim_f = 1'b1;
		lim_r = 1'b1;
		@(posedge clk_in) #1 note(3'd4, 32'h1);
		lim_f = 1'b0;
		lim_r = 1'b0;
		index_pulse = 1'b1;
		@(posedge clk_in) #1 index_pulse = 1'b0;
		wait_done();
		note(3'd3, 32'h1);
		note(3'd0, 32'h0000_0064);
		check({28'h0, act_path}, 32'h1);
		$display("test homing done");
		// clock enable low swallows a trigger edge
		@(posedge clk_in) #1 ce = 1'b0;
		sps_plc_inst.start_path(3'h2);
		ce = 1'b1;
		@(posedge clk_in) #1 note(3'd2, 32'h1);
		note(3'd0, 32'h0000_0064);
		$display("test enable done");
		// emergency halt during a move ramps down like halt
		sps_plc_inst.start_path(3'h2);
		note(3'd0, 32'h0000_0064 + inc);
		@(posedge clk_in) #1 estop = 1'b1;
		repeat (2) @(posedge clk_in) #1;
		estop = 1'b0;
		wait_done();
		check({31'h0, n >= 2 * CPM - 4 && n <= 2 * CPM + 4}, 32'h1);
		$display("test emergency done");
		// second reset, then boot homing at first servo enable
		servo_on = 1'b0;
		reset_n_in = 1'b0;
		repeat (20) @(posedge clk_in);
		#1 reset_n_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#1 wr(sps_pkg::SPS_K_HOMEDEF, 4'h0, 32'h0000_0001);
		servo_on = 1'b1;
		repeat (2) @(posedge clk_in) #1;
		note(3'd4, 32'h1);
		note(3'd2, 32'h0);
		$display("test boot done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
